// ==== shared/cbs_pkg.sv ====
// Package with types, step table and timing counts for the bus cycle sequencer
`default_nettype none
package cbs_pkg;

    localparam int CBS_ADDR_W = 24;
    localparam int CBS_PROG_LEN = 8;
    localparam logic [4:0] CBS_MUL_B_STATES = 5'h0B;
    localparam logic [4:0] CBS_MUL_W_STATES = 5'h13;
    localparam logic [4:0] CBS_ADJ_STATES = 5'h01;
    localparam logic [CBS_ADDR_W-1:0] CBS_WORD_STEP = 24'h00_0002;

    typedef enum logic [4:0] {
        CBS_OP_SINGLE = 5'b00000, CBS_OP_W_ST_D16 = 5'b00001,
        CBS_OP_W_ST_D32 = 5'b00010, CBS_OP_W_ST_PREDEC = 5'b00011,
        CBS_OP_W_ST_AA16 = 5'b00100, CBS_OP_W_ST_AA32 = 5'b00101,
        CBS_OP_L_IMM = 5'b00110, CBS_OP_L_LD_IND = 5'b00111,
        CBS_OP_L_LD_D16 = 5'b01000, CBS_OP_L_LD_D32 = 5'b01001,
        CBS_OP_L_LD_POSTINC = 5'b01010, CBS_OP_L_LD_AA16 = 5'b01011,
        CBS_OP_L_LD_AA32 = 5'b01100, CBS_OP_L_ST_IND = 5'b01101,
        CBS_OP_L_ST_D16 = 5'b01110, CBS_OP_L_ST_D32 = 5'b01111,
        CBS_OP_L_ST_PREDEC = 5'b10000, CBS_OP_L_ST_AA16 = 5'b10001,
        CBS_OP_L_ST_AA32 = 5'b10010, CBS_OP_SMUL_B = 5'b10011,
        CBS_OP_SMUL_W = 5'b10100, CBS_OP_UMUL_B = 5'b10101,
        CBS_OP_UMUL_W = 5'b10110, CBS_OP_MOVE_FROM_PSYNC = 5'b10111,
        CBS_OP_MOVE_TO_PSYNC = 5'b11000
    } cbs_op_t;

    typedef enum logic [2:0] {
        CBS_K_END = 3'b000,
        CBS_K_FETCH = 3'b001,
        CBS_K_INTERNAL = 3'b010,
        CBS_K_READ_EA = 3'b011,
        CBS_K_READ_EA2 = 3'b100,
        CBS_K_WRITE_EA = 3'b101,
        CBS_K_WRITE_EA2 = 3'b110
    } cbs_kind_t;

    typedef struct packed {
        cbs_kind_t kind;
        logic lock;
        logic [4:0] count;
    } cbs_step_t;

    typedef cbs_step_t [CBS_PROG_LEN-1:0] cbs_prog_t;

    typedef struct packed {
        logic req;
        logic write;
        logic fetch;
        logic lock;
        logic [CBS_ADDR_W-1:0] addr;
    } cbs_bus_t;

    localparam cbs_step_t CBS_E = '{kind: CBS_K_END, lock: 1'b0, count: 5'h00};
    localparam cbs_step_t CBS_F = '{kind: CBS_K_FETCH, lock: 1'b0, count: 5'h00};
    localparam cbs_step_t CBS_FM = '{kind: CBS_K_FETCH, lock: 1'b1, count: 5'h00};
    localparam cbs_step_t CBS_I1 = '{kind: CBS_K_INTERNAL, lock: 1'b0, count: CBS_ADJ_STATES};
    localparam cbs_step_t CBS_I11 = '{kind: CBS_K_INTERNAL, lock: 1'b0, count: CBS_MUL_B_STATES};
    localparam cbs_step_t CBS_I19 = '{kind: CBS_K_INTERNAL, lock: 1'b0, count: CBS_MUL_W_STATES};
    localparam cbs_step_t CBS_WE = '{kind: CBS_K_WRITE_EA, lock: 1'b0, count: 5'h00};
    localparam cbs_step_t CBS_REM = '{kind: CBS_K_READ_EA, lock: 1'b1, count: 5'h00};
    localparam cbs_step_t CBS_RE2 = '{kind: CBS_K_READ_EA2, lock: 1'b0, count: 5'h00};
    localparam cbs_step_t CBS_WEM = '{kind: CBS_K_WRITE_EA, lock: 1'b1, count: 5'h00};
    localparam cbs_step_t CBS_WE2 = '{kind: CBS_K_WRITE_EA2, lock: 1'b0, count: 5'h00};

    // Leftmost entry is the first step; unused slots end the instruction
    function automatic cbs_prog_t cbs_program(input cbs_op_t op);
        unique case (op)
            CBS_OP_SINGLE: return {CBS_F, {7{CBS_E}}};
            CBS_OP_W_ST_D16, CBS_OP_W_ST_AA16: return {CBS_F, CBS_F, CBS_WE, {5{CBS_E}}};
            CBS_OP_W_ST_D32: return {CBS_F, CBS_F, CBS_F, CBS_F, CBS_WE, {3{CBS_E}}};
            CBS_OP_W_ST_PREDEC: return {CBS_F, CBS_I1, CBS_WE, {5{CBS_E}}};
            CBS_OP_W_ST_AA32: return {CBS_F, CBS_F, CBS_F, CBS_WE, {4{CBS_E}}};
            CBS_OP_L_IMM: return {CBS_F, CBS_F, CBS_F, {5{CBS_E}}};
            CBS_OP_L_LD_IND: return {CBS_F, CBS_FM, CBS_REM, CBS_RE2, {4{CBS_E}}};
            CBS_OP_L_LD_D16, CBS_OP_L_LD_AA16:
                return {CBS_F, CBS_FM, CBS_F, CBS_REM, CBS_RE2, {3{CBS_E}}};
            CBS_OP_L_LD_D32:
                return {CBS_F, CBS_FM, CBS_FM, CBS_F, CBS_F, CBS_REM, CBS_RE2, CBS_E};
            CBS_OP_L_LD_POSTINC: return {CBS_F, CBS_FM, CBS_I1, CBS_REM, CBS_RE2, {3{CBS_E}}};
            CBS_OP_L_LD_AA32: return {CBS_F, CBS_FM, CBS_F, CBS_F, CBS_REM, CBS_RE2, {2{CBS_E}}};
            CBS_OP_L_ST_IND: return {CBS_F, CBS_FM, CBS_WEM, CBS_WE2, {4{CBS_E}}};
            CBS_OP_L_ST_D16, CBS_OP_L_ST_AA16:
                return {CBS_F, CBS_FM, CBS_F, CBS_WEM, CBS_WE2, {3{CBS_E}}};
            CBS_OP_L_ST_D32:
                return {CBS_F, CBS_FM, CBS_FM, CBS_F, CBS_F, CBS_WEM, CBS_WE2, CBS_E};
            CBS_OP_L_ST_PREDEC: return {CBS_F, CBS_FM, CBS_I1, CBS_WEM, CBS_WE2, {3{CBS_E}}};
            CBS_OP_L_ST_AA32: return {CBS_F, CBS_FM, CBS_F, CBS_F, CBS_WEM, CBS_WE2, {2{CBS_E}}};
            CBS_OP_SMUL_B: return {CBS_F, CBS_F, CBS_I11, {5{CBS_E}}};
            CBS_OP_SMUL_W: return {CBS_F, CBS_F, CBS_I19, {5{CBS_E}}};
            CBS_OP_UMUL_B: return {CBS_F, CBS_I11, {6{CBS_E}}};
            CBS_OP_UMUL_W: return {CBS_F, CBS_I19, {6{CBS_E}}};
            // Peripheral-synchronised moves and illegal codes have no sequence
            default: return {8{CBS_E}};
        endcase
    endfunction

    function automatic logic cbs_is_write(input cbs_kind_t kind);
        return (kind == CBS_K_WRITE_EA) || (kind == CBS_K_WRITE_EA2);
    endfunction

endpackage
`default_nettype wire

// ==== rtl/cbs_step_rom.sv ====
// Step table memory with registered read data
`default_nettype none
module cbs_step_rom
    import cbs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Lookup
    input wire cbs_op_t op_in,
    input wire logic [2:0] idx_in,
    output cbs_step_t step_out
);

    cbs_prog_t prog;
    assign prog = cbs_program(op_in);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_out <= CBS_E;
        end else begin
            step_out <= prog[3'd7 - idx_in];
        end
    end

endmodule
`default_nettype wire

// ==== rtl/cbs_sequencer.sv ====
// Bus cycle sequencer: orders fetches, operand accesses and internal states
// Behaviour
// - Byte multiplies spend eleven bus-free internal states after their fetches.
// - Word multiplies spend nineteen bus-free internal states after their fetches.
// - Peripheral-synchronised moves get no bus cycles; they are flagged unsupported.
// - Word store pre-decrement: fetch next, one internal state, then write at address.
// - Long load post-increment: two fetches, one internal state, read address, address+2.
// - Long store pre-decrement: two fetches, one internal state, write address, address+2.
`default_nettype none
module cbs_sequencer
    import cbs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Instruction request
    input wire logic start_in,
    input wire cbs_op_t op_in,
    input wire logic [CBS_ADDR_W-1:0] pc_in,
    input wire logic [CBS_ADDR_W-1:0] ea_in,
    // Memory bus
    input wire logic bus_ack_in,
    output cbs_bus_t bus_out,
    // Status
    output logic busy_out,
    output logic done_out,
    output logic unsupported_out
);

    // ********************************
    // Reset release
    // ********************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ********************************
    // State and step lookup
    // ********************************
    typedef enum logic [2:0] {
        CBS_ST_IDLE = 3'b000,
        CBS_ST_LOOK = 3'b001,
        CBS_ST_ISSUE = 3'b010,
        CBS_ST_BUS = 3'b011,
        CBS_ST_INT = 3'b100
    } cbs_state_t;

    cbs_state_t state, next_state;
    cbs_op_t op_q, next_op;
    logic [2:0] idx, next_idx;
    logic [4:0] cnt, next_cnt;
    logic [CBS_ADDR_W-1:0] ea_q, next_ea;
    logic [CBS_ADDR_W-1:0] ptr, next_ptr;
    cbs_bus_t next_bus;
    logic next_done;
    logic next_unsupported;
    cbs_step_t step;

    cbs_step_rom u_rom (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .op_in(op_q),
        .idx_in(idx),
        .step_out(step)
    );

    wire logic is_psync = (op_in == CBS_OP_MOVE_FROM_PSYNC) || (op_in == CBS_OP_MOVE_TO_PSYNC);
    wire logic [CBS_ADDR_W-1:0] ea_second = ea_q + CBS_WORD_STEP;
    wire logic step_second = (step.kind == CBS_K_READ_EA2) || (step.kind == CBS_K_WRITE_EA2);
    wire logic step_fetch = (step.kind == CBS_K_FETCH);
    wire logic [CBS_ADDR_W-1:0] step_addr = step_fetch ? ptr : (step_second ? ea_second : ea_q);

    // ********************************
    // Sequencing
    // ********************************
    always_comb begin
        next_state = state;
        next_op = op_q;
        next_idx = idx;
        next_cnt = cnt;
        next_ea = ea_q;
        next_ptr = ptr;
        next_bus = bus_out;
        next_done = 1'b0;
        next_unsupported = 1'b0;
        unique case (state)
            CBS_ST_IDLE: begin
                if (start_in && is_psync) begin
                    next_unsupported = 1'b1;
                end else if (start_in) begin
                    next_op = op_in;
                    next_ea = ea_in;
                    next_ptr = pc_in + CBS_WORD_STEP;
                    next_idx = 3'd0;
                    next_state = CBS_ST_LOOK;
                end
            end
            CBS_ST_LOOK: begin
                next_state = CBS_ST_ISSUE;
            end
            CBS_ST_ISSUE: begin
                unique case (step.kind)
                    CBS_K_INTERNAL: begin
                        next_cnt = step.count;
                        next_state = CBS_ST_INT;
                    end
                    CBS_K_FETCH, CBS_K_READ_EA, CBS_K_READ_EA2,
                    CBS_K_WRITE_EA, CBS_K_WRITE_EA2: begin
                        next_bus.req = 1'b1;
                        next_bus.write = cbs_is_write(step.kind);
                        next_bus.fetch = step_fetch;
                        next_bus.addr = step_addr;
                        next_bus.lock = bus_out.lock | step.lock;
                        next_state = CBS_ST_BUS;
                    end
                    default: begin
                        next_bus.lock = 1'b0;
                        next_done = 1'b1;
                        next_state = CBS_ST_IDLE;
                    end
                endcase
            end
            CBS_ST_BUS: begin
                if (bus_ack_in) begin
                    next_bus.req = 1'b0;
                    next_bus.write = 1'b0;
                    next_bus.fetch = 1'b0;
                    // Lock drops only when an unmarked access ends
                    next_bus.lock = bus_out.lock & step.lock;
                    if (step_fetch) begin
                        next_ptr = ptr + CBS_WORD_STEP;
                    end
                    next_idx = idx + 3'd1;
                    next_state = CBS_ST_LOOK;
                end
            end
            CBS_ST_INT: begin
                next_cnt = cnt - 5'd1;
                if (cnt == 5'd1) begin
                    next_idx = idx + 3'd1;
                    next_state = CBS_ST_LOOK;
                end
            end
            default: begin
                next_state = CBS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= CBS_ST_IDLE;
            op_q <= CBS_OP_SINGLE;
            idx <= 3'd0;
            cnt <= 5'd0;
            ea_q <= '0;
            ptr <= '0;
            bus_out <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            unsupported_out <= 1'b0;
        end else begin
            state <= next_state;
            op_q <= next_op;
            idx <= next_idx;
            cnt <= next_cnt;
            ea_q <= next_ea;
            ptr <= next_ptr;
            bus_out <= next_bus;
            busy_out <= (next_state != CBS_ST_IDLE);
            done_out <= next_done;
            unsupported_out <= next_unsupported;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    wire logic in_int = (state == CBS_ST_INT);
    wire logic mul_b = (op_q == CBS_OP_SMUL_B) || (op_q == CBS_OP_UMUL_B);
    wire logic mul_w = (op_q == CBS_OP_SMUL_W) || (op_q == CBS_OP_UMUL_W);
    wire logic op_long = (op_q >= CBS_OP_L_LD_IND) && (op_q <= CBS_OP_L_ST_AA32);

    a_mul_byte_idle: assert property (
        $rose(in_int) && mul_b |-> (in_int && !bus_out.req) [*8] ##1 (in_int && !bus_out.req) [*3]
            ##1 !in_int)
        else $error("byte multiply internal run is not eleven states");

    a_mul_word_idle: assert property (
        $rose(in_int) && mul_w |-> (in_int && !bus_out.req) [*8] ##1 (in_int && !bus_out.req) [*8]
            ##1 (in_int && !bus_out.req) [*3] ##1 !in_int)
        else $error("word multiply internal run is not nineteen states");

    a_psync_refused: assert property (
        state == CBS_ST_IDLE && start_in && is_psync |=> unsupported_out && !busy_out
            ##1 !bus_out.req)
        else $error("peripheral-synchronised move was not refused");

    a_word_predec_write: assert property (
        $rose(in_int) && op_q == CBS_OP_W_ST_PREDEC |-> ##1 state == CBS_ST_LOOK
            ##2 (bus_out.req && bus_out.write && !bus_out.fetch && bus_out.addr == ea_q))
        else $error("word pre-decrement store did not write after one internal state");

    a_long_load_pair: assert property (
        bus_out.req && bus_ack_in && !bus_out.write && !bus_out.fetch
            && bus_out.addr == ea_q && op_q == CBS_OP_L_LD_POSTINC
            |-> ##3 (bus_out.req && !bus_out.write && bus_out.addr == ea_second))
        else $error("long post-increment load missed the second word read");

    a_long_store_pair: assert property (
        bus_out.req && bus_ack_in && bus_out.write && bus_out.addr == ea_q
            && op_q == CBS_OP_L_ST_PREDEC
            |-> ##3 (bus_out.req && bus_out.write && bus_out.addr == ea_second))
        else $error("long pre-decrement store missed the second word write");

    a_lock_first_word: assert property (
        bus_out.req && !bus_out.fetch && bus_out.addr == ea_q && op_long |-> bus_out.lock)
        else $error("bus not locked on the first word of a longword");

    a_lock_released: assert property (
        bus_out.req && bus_ack_in && !bus_out.fetch && bus_out.addr == ea_second && op_long
            |=> !bus_out.lock)
        else $error("bus lock held past the final operand word");

endmodule
`default_nettype wire

// ==== bench/cbs_mem_model.sv ====
// Memory-side partner that acknowledges each bus cycle after a chosen wait
`default_nettype none
module cbs_mem_model
    import cbs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Bus from the sequencer
    input wire cbs_bus_t bus_in,
    input wire logic [3:0] wait_in,
    output logic ack_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt;

    // The acknowledge is a single cycle; the cycle after it is skipped
    // because the request is still high while it falls
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_out <= 1'h0;
            cnt <= 4'h0;
        end else if (ack_out) begin
            ack_out <= 1'h0;
            cnt <= 4'h0;
        end else if (bus_in.req && cnt == wait_in) begin
            ack_out <= 1'h1;
        end else if (bus_in.req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench for the bus cycle sequencer
`default_nettype none
module tb
    import cbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [23:0] PC = 24'h00_1000;
    localparam logic [23:0] EA = 24'h00_4000;
    logic clock_in = 1'h0;
    logic nrst_in = 1'h0;
    logic start_in = 1'h0;
    cbs_op_t op_in = CBS_OP_SINGLE;
    logic [23:0] pc_in = PC;
    logic [23:0] ea_in = EA;
    logic [3:0] mem_wait = 4'h0;
    logic bus_ack;
    cbs_bus_t bus_out;
    logic busy_out;
    logic done_out;
    logic unsupported_out;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n_log, rises, lock_fall, done_cyc, base_done, base_gap, long_gap, busy_cnt;
    bit done_seen, unsup_seen, busy_seen;
    logic prev_lock = 1'h0;
    logic [26:0] lg [16];
    int lg_c [16];

    cbs_sequencer cbs_sequencer_i (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(start_in),
        .op_in(op_in), .pc_in(pc_in), .ea_in(ea_in), .bus_ack_in(bus_ack), .bus_out(bus_out),
        .busy_out(busy_out), .done_out(done_out), .unsupported_out(unsupported_out));
    cbs_mem_model cbs_mem_model_i (.clock_in(clock_in), .nrst_in(nrst_in), .bus_in(bus_out),
        .wait_in(mem_wait), .ack_out(bus_ack));

    always #5 clock_in = ~clock_in;

    // ****************************************
    // Bus monitor: logs {write, fetch, lock, addr} at each acknowledge edge
    // ****************************************
    always @(posedge clock_in) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            report_and_stop();
        end
        if (bus_out.req && bus_ack && n_log < 16) begin
            lg[n_log] = {bus_out.write, bus_out.fetch, bus_out.lock, bus_out.addr};
            lg_c[n_log] = cyc;
            n_log++;
        end
        if (bus_out.lock && !prev_lock) rises++;
        if (!bus_out.lock && prev_lock) lock_fall = cyc;
        prev_lock = bus_out.lock;
        if (done_out) begin
            done_seen = 1;
            done_cyc = cyc;
        end
        if (unsupported_out) unsup_seen = 1;
        // Unknown counts as busy so the refusal check cannot pass on it
        if (busy_out !== 1'h0) busy_seen = 1;
        if (busy_out === 1'h1) busy_cnt++;
    end

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic report_and_stop();
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int i, input logic [26:0] exp);
        chk({5'h00, lg[i]}, {5'h00, exp});
    endtask

    // Starts one instruction and waits, bounded, for its completion pulse
    task automatic run(input cbs_op_t op);
        @(negedge clock_in);
        n_log = 0;
        rises = 0;
        lock_fall = 0;
        done_seen = 0;
        unsup_seen = 0;
        busy_seen = 0;
        busy_cnt = 0;
        @(posedge clock_in);
        start_in <= 1'h1;
        op_in <= op;
        @(posedge clock_in);
        start_in <= 1'h0;
        for (int k = 0; k < 600 && !(done_seen || unsup_seen); k++) @(negedge clock_in);
        chk(done_seen || unsup_seen, 1);
        // A hung sequence would poison every later scenario
        if (!(done_seen || unsup_seen)) report_and_stop();
        repeat (2) @(negedge clock_in);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_single();
        run(CBS_OP_SINGLE);
        chk(n_log, 1);
        chk_cyc(0, {3'h2, PC + 24'h00_0002});
        base_done = done_cyc - lg_c[0];
        chk(unsup_seen, 0);
        // Busy from the cycle after the start edge until the completion pulse
        chk(busy_cnt, base_done + 3);
    endtask

    task automatic t_mul();
        cbs_op_t ops [4] = '{CBS_OP_SMUL_B, CBS_OP_SMUL_W, CBS_OP_UMUL_B, CBS_OP_UMUL_W};
        int nf [4] = '{2, 2, 1, 1};
        int ns [4] = '{11, 19, 11, 19};
        for (int i = 0; i < 4; i++) begin
            run(ops[i]);
            chk(n_log, nf[i]);
            for (int j = 0; j < nf[i]; j++) chk_cyc(j, {3'h2, PC + 24'(2 * j + 2)});
            // Internal states add their count plus the step lookup overhead
            chk(done_cyc - lg_c[nf[i] - 1], base_done + ns[i] + 2);
        end
    endtask

    task automatic t_psync();
        cbs_op_t ops [2] = '{CBS_OP_MOVE_FROM_PSYNC, CBS_OP_MOVE_TO_PSYNC};
        for (int i = 0; i < 2; i++) begin
            run(ops[i]);
            chk(unsup_seen, 1);
            chk(n_log, 0);
            chk(busy_seen, 0);
        end
    endtask

    task automatic t_word_store();
        run(CBS_OP_W_ST_D16);
        chk(n_log, 3);
        chk_cyc(2, {3'h4, EA});
        base_gap = lg_c[2] - lg_c[1];
        run(CBS_OP_W_ST_PREDEC);
        chk(n_log, 2);
        chk_cyc(0, {3'h2, PC + 24'h00_0002});
        chk_cyc(1, {3'h4, EA});
        chk(lg_c[1] - lg_c[0], base_gap + 3);
    endtask

    // Longword access pair with lock held from the marked fetch to the last word
    task automatic long_chk(input logic [2:0] kind, input int gap);
        chk(n_log, 4);
        chk_cyc(0, {3'h2, PC + 24'h00_0002});
        chk_cyc(1, {3'h3, PC + 24'h00_0004});
        chk_cyc(2, {kind, EA});
        chk_cyc(3, {kind, EA + 24'h00_0002});
        chk(rises, 1);
        chk(lock_fall > lg_c[3] && lock_fall <= lg_c[3] + 2, 1);
        if (gap > 0) chk(lg_c[2] - lg_c[1], gap);
    endtask

    task automatic t_long();
        // Slow memory stretches each cycle so the lock window spans waits
        @(posedge clock_in);
        mem_wait <= 4'h3;
        run(CBS_OP_L_LD_IND);
        long_chk(3'h1, 0);
        long_gap = lg_c[2] - lg_c[1];
        run(CBS_OP_L_LD_POSTINC);
        long_chk(3'h1, long_gap + 3);
        run(CBS_OP_L_ST_PREDEC);
        long_chk(3'h5, long_gap + 3);
    endtask

    // Other addressing forms: the fetch run, then the operand words with their lock
    task automatic t_forms();
        cbs_op_t ops [13] = '{CBS_OP_W_ST_D32, CBS_OP_W_ST_AA16, CBS_OP_W_ST_AA32,
            CBS_OP_L_IMM, CBS_OP_L_LD_D16, CBS_OP_L_LD_D32, CBS_OP_L_LD_AA16,
            CBS_OP_L_LD_AA32, CBS_OP_L_ST_IND, CBS_OP_L_ST_D16, CBS_OP_L_ST_D32,
            CBS_OP_L_ST_AA16, CBS_OP_L_ST_AA32};
        int na [13] = '{5, 3, 4, 3, 5, 7, 5, 6, 4, 5, 7, 5, 6};
        int no [13] = '{1, 1, 1, 0, 2, 2, 2, 2, 2, 2, 2, 2, 2};
        bit wr [13] = '{1, 1, 1, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
        int nf;
        for (int i = 0; i < 13; i++) begin
            run(ops[i]);
            nf = na[i] - no[i];
            chk(n_log, na[i]);
            for (int k = 0; k < nf; k++)
                chk({lg[k][26:25], lg[k][23:0]}, {2'h1, PC + 24'(2 * k + 2)});
            for (int j = 0; j < no[i]; j++)
                chk_cyc(nf + j, {wr[i], 1'b0, no[i] == 2, EA + 24'(2 * j)});
        end
        // An undefined class code completes without any bus cycle
        run(cbs_op_t'(5'h1F));
        chk(n_log, 0);
        chk(done_seen, 1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clock_in);
        nrst_in <= 1'h1;
        repeat (5) @(posedge clock_in);
        t_single();
        t_mul();
        t_psync();
        t_word_store();
        t_long();
        t_forms();
        report_and_stop();
    end
endmodule
`default_nettype wire
